// ==== include/ibsa_cfg.svh ====
// Constants of the instrument bus service access block
`ifndef IBSA_CFG_SVH
`define IBSA_CFG_SVH

// ****************************************************************
// Instrument bus locations
// ****************************************************************
`define IBSA_LOC_SWEEP_A 8'h0F
`define IBSA_LOC_SWEEP_B 8'h1F
`define IBSA_LOC_READOUT_CHAR 8'h2F
`define IBSA_LOC_VAR_RES 8'h3F
`define IBSA_LOC_ZAXIS_ATTEN 8'h4F
`define IBSA_LOC_READOUT_CTRL 8'h5F
`define IBSA_LOC_FDAC_CTRL 8'h70
`define IBSA_LOC_FDAC_VALUE 8'h71
`define IBSA_LOC_LO_DRIVER 8'h72
`define IBSA_LOC_SPAN_A 8'h75
`define IBSA_LOC_SPAN_B 8'h76
`define IBSA_LOC_PRESEL_CTRL 8'h77
`define IBSA_LOC_VIDEO_OFFSET 8'h78
`define IBSA_LOC_DISP_MODE 8'h79
`define IBSA_LOC_STORE_WR 8'h7A
`define IBSA_LOC_STORE_CTRL 8'h7B
`define IBSA_LOC_VIDEO_PROC 8'h7C
`define IBSA_LOC_PEAK_ADJ 8'h7E
`define IBSA_LOC_SUPPLY_STAT 8'hCF
`define IBSA_LOC_DAC_COMPARE 8'hF0
`define IBSA_LOC_PRESEL_FIT 8'hF7
`define IBSA_LOC_STORE_RD 8'hFA

// ****************************************************************
// Fields, codes and counts
// ****************************************************************
`define IBSA_DIR_BIT 7
`define IBSA_STEER_BIT 7
`define IBSA_FITTED_BIT 3
`define IBSA_ERR_ARG 8'h41
`define IBSA_ERR_DIR 8'h42
`define IBSA_MAX_PAIRS 5'h10
`define IBSA_ADDR_RESET 8'h00
`define IBSA_RES_BW_RESET 3'h0
`define IBSA_GAIN_RESET 7'h00
`define IBSA_SETUP_CYC 4'h2
`define IBSA_HOLD_CYC 4'h4

`endif

// ==== include/ibsa_pkg.sv ====
// Types of the instrument bus service access block
package ibsa_pkg;

    typedef enum logic [1:0] {
        IBSA_CMD_ADDR_SET = 2'b00,
        IBSA_CMD_ADDR_QRY = 2'b01,
        IBSA_CMD_DATA_SET = 2'b10,
        IBSA_CMD_DATA_QRY = 2'b11
    } ibsa_cmd_t;

    typedef enum logic [2:0] {
        IBSA_BUS_IDLE = 3'b000,
        IBSA_BUS_SETUP = 3'b001,
        IBSA_BUS_RISE = 3'b010,
        IBSA_BUS_DRIVE = 3'b011,
        IBSA_BUS_HOLD = 3'b100,
        IBSA_BUS_UNDRIVE = 3'b101,
        IBSA_BUS_FALL = 3'b110
    } ibsa_bus_t;

endpackage

// ==== rtl/ibsa_top.sv ====
// Service command interpreter driving the byte-wide instrument bus
`timescale 1ns/1ps
`include "ibsa_cfg.svh"

// What this block does
// (R1) Keep current address; set, report, target it
// (R2) Two hex characters, first is high nibble
// (R3) Bad or lone address character: error, no change
// (R4) Each data pair goes to current address
// (R5) Accept at most sixteen pairs per command
// (R6) Bad data pair skipped and error reported
// (R7) Data to an invalid location reports error
// (R8) Data query reads current location back
// (R9) Address then data in one message works
// (R10) Code 41 bad argument, 42 wrong direction
// (R11) Steering bit set: low three bits to bandwidth
// (R12) Steering bit clear: seven bits to gain
// (R13) 78 video offset, 79 display mode and scale
// (R14) 7A writes display data, FA reads, 7B storage
// (R15) 4F z-axis/attenuator enable, CF supply status
// (R16) 5F readout control, 2F readout characters
// (R17) 0F and 1F sweep control writes
// (R18) 75 and 76 set span attenuator
// (R19) 72 LO driver, 7E preselector tune trim
// (R20) 77 preselector control, F7 bit 3 fitted
// (R21) 70 control, 71 DAC value, F0 compare
// (R22) 7C video processor control
// (R23) Address moves with strobe low, data high
// (R24) Address bit 7 set means read location
module ibsa_top
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic cmd_start_in,
    input wire logic [1:0] cmd_kind_in,
    input wire logic char_valid_in,
    input wire logic [7:0] char_in,
    input wire logic cmd_end_in,
    output logic ready_out,
    output logic resp_valid_out,
    output logic [7:0] resp_byte_out,
    output logic err_valid_out,
    output logic [7:0] err_code_out,
    output logic [7:0] cur_addr_out,
    output logic [2:0] res_bw_sel_out,
    output logic [6:0] gain_level_out,
    output logic [7:0] ibus_addr_out,
    output logic ibus_valid_out,
    output logic [7:0] ibus_data_out,
    output logic ibus_data_oe_out,
    input wire logic [7:0] ibus_data_in,
    input wire logic board_fitted_flag_in
);

    // ************************************************************
    // Functions
    // ************************************************************

    // Upper-case hex only; bit 4 flags a legal digit
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        logic [4:0] r;
        r = 5'h00;
        if (c >= 8'h30 && c <= 8'h39)
            r = {1'b1, c[3:0]};
        else if (c >= 8'h41 && c <= 8'h46)
            r = {1'b1, 4'(c[3:0] + 4'h9)};
        return r;
    endfunction

    function automatic logic is_write_loc(input logic [7:0] a);
        logic r;
        r = 1'b0;
        case (a)
            `IBSA_LOC_SWEEP_A, `IBSA_LOC_SWEEP_B: r = 1'b1; // R17
            `IBSA_LOC_READOUT_CHAR, `IBSA_LOC_READOUT_CTRL:
                r = 1'b1; // R16
            `IBSA_LOC_VAR_RES: r = 1'b1; // R11
            `IBSA_LOC_ZAXIS_ATTEN: r = 1'b1; // R15
            `IBSA_LOC_FDAC_CTRL, `IBSA_LOC_FDAC_VALUE: r = 1'b1; // R21
            `IBSA_LOC_LO_DRIVER, `IBSA_LOC_PEAK_ADJ: r = 1'b1; // R19
            `IBSA_LOC_SPAN_A, `IBSA_LOC_SPAN_B: r = 1'b1; // R18
            `IBSA_LOC_PRESEL_CTRL: r = 1'b1; // R20
            `IBSA_LOC_VIDEO_OFFSET, `IBSA_LOC_DISP_MODE:
                r = 1'b1; // R13
            `IBSA_LOC_STORE_WR, `IBSA_LOC_STORE_CTRL: r = 1'b1; // R14
            `IBSA_LOC_VIDEO_PROC: r = 1'b1; // R22
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic is_read_loc(input logic [7:0] a);
        logic r;
        r = 1'b0;
        case (a)
            `IBSA_LOC_SUPPLY_STAT: r = 1'b1; // R15
            `IBSA_LOC_DAC_COMPARE: r = 1'b1; // R21
            `IBSA_LOC_PRESEL_FIT: r = 1'b1; // R20
            `IBSA_LOC_STORE_RD: r = 1'b1; // R14
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    ibsa_pkg::ibsa_cmd_t kind_q;
    ibsa_pkg::ibsa_bus_t bus_q;
    logic active_q;
    logic half_q;
    logic pair_bad_q;
    logic [3:0] hi_nib_q;
    logic [4:0] pairs_q;
    logic [4:0] nib;
    logic [7:0] pair_byte;
    logic char_take;
    logic pair_done;
    logic start_take;
    logic end_take;
    logic launch_wr;
    logic launch_rd;
    logic bus_busy_q;
    logic bus_read_q;
    logic [7:0] wr_byte_q;
    logic [3:0] cnt_q;
    logic [7:0] rd_meta_q;
    logic [7:0] rd_sync_q;
    logic fit_meta_q;
    logic fit_sync_q;
    logic err_set;
    logic [7:0] err_code;

    // ************************************************************
    // Command intake
    // ************************************************************
    assign start_take = cmd_start_in && ready_out && !active_q;
    assign char_take = char_valid_in && ready_out && active_q;
    assign end_take = cmd_end_in && ready_out && active_q;
    assign nib = hex_val(char_in);
    assign pair_byte = {hi_nib_q, nib[3:0]}; // R2
    assign pair_done = char_take && half_q;

    // A finished data pair goes out only if both digits were legal,
    // the pair count is within limit and the location accepts it
    assign launch_wr = pair_done && kind_q == ibsa_pkg::IBSA_CMD_DATA_SET
        && !pair_bad_q && nib[4] && pairs_q < `IBSA_MAX_PAIRS // R5 R6
        && !cur_addr_out[`IBSA_DIR_BIT] // R24
        && is_write_loc(cur_addr_out); // R7

    assign launch_rd = start_take
        && cmd_kind_in == ibsa_pkg::IBSA_CMD_DATA_QRY
        && cur_addr_out[`IBSA_DIR_BIT] // R24
        && is_read_loc(cur_addr_out);

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            active_q <= 1'b0;
            kind_q <= ibsa_pkg::IBSA_CMD_ADDR_SET;
        end
        else if (start_take)
        begin
            // Queries carry no argument and finish on the start
            active_q <= cmd_kind_in == ibsa_pkg::IBSA_CMD_ADDR_SET
                || cmd_kind_in == ibsa_pkg::IBSA_CMD_DATA_SET;
            kind_q <= ibsa_pkg::ibsa_cmd_t'(cmd_kind_in);
        end
        else if (end_take)
        begin
            active_q <= 1'b0;
        end
    end

    // Pair assembly state
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in || start_take)
        begin
            half_q <= 1'b0;
            pair_bad_q <= 1'b0;
            hi_nib_q <= 4'h0;
            pairs_q <= 5'h00;
        end
        else if (char_take)
        begin
            half_q <= !half_q;
            if (!half_q)
            begin
                hi_nib_q <= nib[3:0];
                pair_bad_q <= !nib[4];
            end
            else if (pairs_q < `IBSA_MAX_PAIRS)
            begin
                pairs_q <= 5'(pairs_q + 5'h01);
            end
        end
    end

    // Address register: only the first pair of the argument is taken,
    // and only if both its digits are legal; later pairs leave it untouched
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
            cur_addr_out <= `IBSA_ADDR_RESET;
        else if (pair_done && kind_q == ibsa_pkg::IBSA_CMD_ADDR_SET
            && pairs_q == 5'h00 && !pair_bad_q && nib[4]) // R1 R3 R9
            cur_addr_out <= pair_byte;
    end

    // ************************************************************
    // Error reporting
    // ************************************************************
    always_comb
    begin
        err_set = 1'b0;
        err_code = `IBSA_ERR_ARG;
        if (pair_done && (pair_bad_q || !nib[4]))
        begin
            err_set = 1'b1; // R3 R6 R10
        end
        else if (pair_done && pairs_q >= 5'h01
            && kind_q == ibsa_pkg::IBSA_CMD_ADDR_SET)
        begin
            err_set = 1'b1; // R3
        end
        else if (pair_done && pairs_q >= `IBSA_MAX_PAIRS)
        begin
            err_set = 1'b1; // R5
        end
        else if (pair_done && kind_q == ibsa_pkg::IBSA_CMD_DATA_SET)
        begin
            if (cur_addr_out[`IBSA_DIR_BIT])
            begin
                err_set = 1'b1;
                err_code = `IBSA_ERR_DIR; // R10 R24
            end
            else if (!is_write_loc(cur_addr_out))
            begin
                err_set = 1'b1; // R7
            end
        end
        else if (end_take && (half_q
            || (kind_q == ibsa_pkg::IBSA_CMD_ADDR_SET
            && pairs_q == 5'h00)))
        begin
            err_set = 1'b1; // R3 R6
        end
        else if (start_take
            && cmd_kind_in == ibsa_pkg::IBSA_CMD_DATA_QRY)
        begin
            if (!cur_addr_out[`IBSA_DIR_BIT])
            begin
                err_set = 1'b1;
                err_code = `IBSA_ERR_DIR; // R10 R24
            end
            else if (!is_read_loc(cur_addr_out))
            begin
                err_set = 1'b1; // R7
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            err_valid_out <= 1'b0;
            err_code_out <= 8'h00;
        end
        else
        begin
            err_valid_out <= err_set;
            if (err_set)
                err_code_out <= err_code;
        end
    end

    // ************************************************************
    // Answers to the controller
    // ************************************************************
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            resp_valid_out <= 1'b0;
            resp_byte_out <= 8'h00;
        end
        else if (start_take
            && cmd_kind_in == ibsa_pkg::IBSA_CMD_ADDR_QRY)
        begin
            resp_valid_out <= 1'b1;
            resp_byte_out <= cur_addr_out; // R1
        end
        else if (bus_q == ibsa_pkg::IBSA_BUS_UNDRIVE && bus_read_q)
        begin
            resp_valid_out <= 1'b1;
            // The fitted flag comes from this board itself
            if (ibus_addr_out == `IBSA_LOC_PRESEL_FIT)
            begin
                resp_byte_out <= 8'h00;
                resp_byte_out[`IBSA_FITTED_BIT] <= fit_sync_q; // R20
            end
            else
            begin
                resp_byte_out <= rd_sync_q; // R8
            end
        end
        else
        begin
            resp_valid_out <= 1'b0;
        end
    end

    // Ready drops the cycle after a bus transfer is launched and
    // returns when the strobe has fallen again
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
            ready_out <= 1'b1;
        else if (launch_wr || launch_rd)
            ready_out <= 1'b0;
        else if (bus_q == ibsa_pkg::IBSA_BUS_FALL)
            ready_out <= 1'b1;
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            rd_meta_q <= 8'h00;
            rd_sync_q <= 8'h00;
            fit_meta_q <= 1'b0;
            fit_sync_q <= 1'b0;
        end
        else
        begin
            rd_meta_q <= ibus_data_in;
            rd_sync_q <= rd_meta_q;
            fit_meta_q <= board_fitted_flag_in;
            fit_sync_q <= fit_meta_q;
        end
    end

    // ************************************************************
    // Instrument bus sequencer
    // ************************************************************
    // Address settles while the strobe is low, data moves only
    // while it is high, so a board never latches a mixed pair
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            bus_q <= ibsa_pkg::IBSA_BUS_IDLE;
            bus_busy_q <= 1'b0;
            bus_read_q <= 1'b0;
            wr_byte_q <= 8'h00;
            cnt_q <= 4'h0;
            ibus_addr_out <= 8'h00;
            ibus_valid_out <= 1'b0;
            ibus_data_out <= 8'h00;
            ibus_data_oe_out <= 1'b0;
        end
        else
        begin
            unique case (bus_q)
                ibsa_pkg::IBSA_BUS_IDLE:
                begin
                    if (launch_wr || launch_rd)
                    begin
                        bus_q <= ibsa_pkg::IBSA_BUS_SETUP;
                        bus_busy_q <= 1'b1;
                        bus_read_q <= launch_rd;
                        wr_byte_q <= pair_byte; // R4
                        ibus_addr_out <= cur_addr_out; // R23
                        cnt_q <= `IBSA_SETUP_CYC;
                    end
                end
                ibsa_pkg::IBSA_BUS_SETUP:
                begin
                    if (cnt_q == 4'h1)
                        bus_q <= ibsa_pkg::IBSA_BUS_RISE;
                    else
                        cnt_q <= 4'(cnt_q - 4'h1);
                end
                ibsa_pkg::IBSA_BUS_RISE:
                begin
                    ibus_valid_out <= 1'b1;
                    bus_q <= ibsa_pkg::IBSA_BUS_DRIVE;
                end
                ibsa_pkg::IBSA_BUS_DRIVE:
                begin
                    ibus_data_out <= wr_byte_q; // R23
                    ibus_data_oe_out <= !bus_read_q;
                    cnt_q <= `IBSA_HOLD_CYC;
                    bus_q <= ibsa_pkg::IBSA_BUS_HOLD;
                end
                ibsa_pkg::IBSA_BUS_HOLD:
                begin
                    // Long enough for read data to clear the sync
                    if (cnt_q == 4'h1)
                        bus_q <= ibsa_pkg::IBSA_BUS_UNDRIVE;
                    else
                        cnt_q <= 4'(cnt_q - 4'h1);
                end
                ibsa_pkg::IBSA_BUS_UNDRIVE:
                begin
                    ibus_data_oe_out <= 1'b0; // R23
                    bus_q <= ibsa_pkg::IBSA_BUS_FALL;
                end
                ibsa_pkg::IBSA_BUS_FALL:
                begin
                    ibus_valid_out <= 1'b0;
                    bus_busy_q <= 1'b0;
                    bus_q <= ibsa_pkg::IBSA_BUS_IDLE;
                end
                default:
                begin
                    bus_q <= ibsa_pkg::IBSA_BUS_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Variable resolution shadow
    // ************************************************************
    // Same byte, two destinations chosen by the steering bit
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            res_bw_sel_out <= `IBSA_RES_BW_RESET;
            gain_level_out <= `IBSA_GAIN_RESET;
        end
        else if (launch_wr && cur_addr_out == `IBSA_LOC_VAR_RES)
        begin
            if (pair_byte[`IBSA_STEER_BIT])
                res_bw_sel_out <= pair_byte[2:0]; // R11
            else
                gain_level_out <= pair_byte[6:0]; // R12
        end
    end

endmodule // ibsa_top

// ==== testbench/ibsa_bench.sv ====
// Testbench of the instrument bus service access block
`timescale 1ns/1ps
module ibsa_bench;
    localparam logic [7:0] SUP = 8'h3C;
    localparam logic [7:0] CMP = 8'h96;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cmd_start_in = 1'b0;
    logic [1:0] cmd_kind_in = 2'h0;
    logic char_valid_in = 1'b0;
    logic [7:0] char_in = 8'h00;
    logic cmd_end_in = 1'b0;
    logic board_fitted_flag_in = 1'b0;
    logic ready_out, resp_valid_out, err_valid_out, ibus_valid_out;
    logic ibus_data_oe_out;
    logic [7:0] resp_byte_out, err_code_out, cur_addr_out, ibus_addr_out;
    logic [7:0] ibus_data_out, ibus_data_in, wr_addr, wr_data;
    logic [7:0] last_resp, last_err;
    logic [7:0] q[$];
    logic [2:0] res_bw_sel_out;
    logic [6:0] gain_level_out;
    int wr_cnt, err_count = 0, checks_done = 0, ev_err = 0, e0 = 0, w0 = 0;
    int cycles = 0;
    logic [7:0] wl[16] = '{8'h0F, 8'h1F, 8'h2F, 8'h4F, 8'h5F, 8'h70, 8'h71,
        8'h72, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7B, 8'h7C, 8'h7E};

    ibsa_top uut (.*);
    ibsa_ibus_model #(.SUPPLY_WORD(SUP), .COMPARE_WORD(CMP)) bus_i (
        .core_clk_in, .ibus_addr_in(ibus_addr_out),
        .ibus_valid_in(ibus_valid_out), .ibus_data_in(ibus_data_out),
        .ibus_data_oe_in(ibus_data_oe_out), .ibus_data_out(ibus_data_in),
        .wr_addr_out(wr_addr), .wr_data_out(wr_data), .wr_count_out(wr_cnt));

    initial
    begin
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    // Pulses stand one cycle: catch them at each edge
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (resp_valid_out === 1'b1)
            last_resp = resp_byte_out;
        if (err_valid_out === 1'b1)
        begin
            ev_err++;
            last_err = err_code_out;
        end
        if (cycles == 20000)
        begin
            err_count++;
            stop_test();
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // what: 0 start, 1 char, 2 end; offered once ready
    task put(input int what, input logic [7:0] v);
        for (int n = 0; n == 0 || ready_out !== 1'b1 && n < 200; n++)
        begin
            @(posedge core_clk_in);
            #1;
        end
        if (what == 0)
        begin
            cmd_start_in = 1'b1;
            cmd_kind_in = v[1:0];
        end
        else if (what == 1)
        begin
            char_valid_in = 1'b1;
            char_in = v;
        end
        else
            cmd_end_in = 1'b1;
        @(posedge core_clk_in);
        #1;
        cmd_start_in = 1'b0;
        char_valid_in = 1'b0;
        cmd_end_in = 1'b0;
    endtask

    task settle;
        repeat (2) @(posedge core_clk_in);
        for (int n = 0; ready_out !== 1'b1 && n < 200; n++)
            @(posedge core_clk_in);
        @(posedge core_clk_in);
        #1;
    endtask

    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction

    task send(input logic [1:0] kind, input logic [7:0] b[$]);
        put(0, {6'h00, kind});
        foreach (b[i])
        begin
            put(1, hx(b[i][7:4]));
            put(1, hx(b[i][3:0]));
        end
        put(2, 8'h00);
        settle();
    endtask

    task send_text(input logic [1:0] kind, input string s);
        put(0, {6'h00, kind});
        for (int i = 0; i < s.len(); i++)
            put(1, s[i]);
        put(2, 8'h00);
        settle();
    endtask

    task query(input logic [7:0] a);
        send(2'h0, '{a});
        put(0, 8'h03);
        settle();
    endtask

    task tally(input int ne, input int nw, input logic [7:0] code);
        check(8'(ev_err - e0), 8'(ne));
        check(8'(wr_cnt - w0), 8'(nw));
        if (ne > 0)
            check(last_err, code);
        e0 = ev_err;
        w0 = wr_cnt;
    endtask

    task stop_test;
        $display("Counts: %0d checks, %0d mismatches", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    initial
    begin
        repeat (20) @(posedge core_clk_in);
        #1;
        rst_in = 1'b0;
        check(cur_addr_out, 8'h00);
        check({7'h00, ready_out}, 8'h01);
        $display("Test reset done");
        board_fitted_flag_in = 1'b1;
        send(2'h0, '{8'h7A});
        check(cur_addr_out, 8'h7A);
        put(0, 8'h01);
        settle();
        check(last_resp, 8'h7A);
        send(2'h2, '{8'h5A, 8'hC3});
        check(wr_addr, 8'h7A);
        check(wr_data, 8'hC3);
        query(8'hFA);
        check(last_resp, 8'hC3);
        query(8'hCF);
        check(last_resp, SUP);
        query(8'hF0);
        check(last_resp, CMP);
        query(8'hF7);
        check(last_resp, 8'h08);
        board_fitted_flag_in = 1'b0;
        query(8'hF7);
        check(last_resp, 8'h00);
        tally(0, 2, 8'h00);
        $display("Test basic access done");
        foreach (wl[i])
        begin
            send(2'h0, '{wl[i]});
            send(2'h2, '{wl[i] ^ 8'h5A});
            check(wr_addr, wl[i]);
            check(wr_data, wl[i] ^ 8'h5A);
        end
        tally(0, 16, 8'h00);
        send(2'h0, '{8'h3F});
        send(2'h2, '{8'h85});
        check({5'h00, res_bw_sel_out}, 8'h05);
        send(2'h2, '{8'h2A});
        check({1'b0, gain_level_out}, 8'h2A);
        check({5'h00, res_bw_sel_out}, 8'h05);
        $display("Test write map done");
        send(2'h0, '{8'h78});
        tally(0, 2, 8'h00);
        q = {};
        for (int i = 0; i < 17; i++)
            q.push_back(8'(i));
        send(2'h2, q);
        tally(1, 16, 8'h41);
        check(wr_data, 8'h0F);
        $display("Test pair limit done");
        send_text(2'h0, "G1");
        tally(1, 0, 8'h41);
        check(cur_addr_out, 8'h78);
        send_text(2'h0, "7");
        tally(1, 0, 8'h41);
        send_text(2'h0, "ab");
        tally(1, 0, 8'h41);
        send_text(2'h2, "1Z33");
        tally(1, 1, 8'h41);
        check(wr_data, 8'h33);
        send_text(2'h2, "445");
        tally(1, 1, 8'h41);
        send(2'h0, '{8'h60});
        send(2'h2, '{8'h11});
        tally(1, 0, 8'h41);
        send(2'h0, '{8'hF0});
        send(2'h2, '{8'h11});
        tally(1, 0, 8'h42);
        query(8'h78);
        tally(1, 0, 8'h42);
        query(8'hFF);
        tally(1, 0, 8'h41);
        $display("Test errors done");
        stop_test();
    end
endmodule // ibsa_bench

// ==== testbench/ibsa_ibus_model.sv ====
// Model of the assemblies that answer on the instrument bus
`timescale 1ns/1ps
module ibsa_ibus_model
#(
    parameter logic [7:0] SUPPLY_WORD = 8'h3C,
    parameter logic [7:0] COMPARE_WORD = 8'h96
)
(
    input logic core_clk_in,
    input logic [7:0] ibus_addr_in,
    input logic ibus_valid_in,
    input logic [7:0] ibus_data_in,
    input logic ibus_data_oe_in,
    output logic [7:0] ibus_data_out,
    output logic [7:0] wr_addr_out,
    output logic [7:0] wr_data_out,
    output int wr_count_out
);
    logic wr_seen = 1'b0;
    logic [7:0] store = 8'h00;

    initial
    begin
        ibus_data_out = 8'h00;
        wr_addr_out = 8'h00;
        wr_data_out = 8'h00;
        wr_count_out = 0;
    end

    always @(posedge core_clk_in)
    begin
        if (ibus_valid_in && ibus_data_oe_in)
        begin
            wr_seen = 1'b1;
            wr_addr_out = ibus_addr_in;
            wr_data_out = ibus_data_in;
        end
        if (!ibus_valid_in && wr_seen)
        begin
            wr_seen = 1'b0;
            wr_count_out++;
            if (wr_addr_out == 8'h7A)
                store = wr_data_out;
        end
        // Unselected lines wander: show the inverse
        if (ibus_valid_in && !ibus_data_oe_in && ibus_addr_in[7])
            case (ibus_addr_in)
                8'hFA: ibus_data_out <= store;
                8'hCF: ibus_data_out <= SUPPLY_WORD;
                8'hF0: ibus_data_out <= COMPARE_WORD;
                default: ibus_data_out <= 8'hFF;
            endcase
        else
            ibus_data_out <= ~ibus_data_out;
    end
endmodule // ibsa_ibus_model

// ==== testbench/ibsa_top_chk.sv ====
// Port checker of the instrument bus service access block
`timescale 1ns/1ps
module ibsa_top_chk
(
    input logic core_clk_in,
    input logic rst_in,
    input logic cmd_start_in,
    input logic [1:0] cmd_kind_in,
    input logic cmd_end_in,
    input logic ready_out,
    input logic resp_valid_out,
    input logic [7:0] resp_byte_out,
    input logic err_valid_out,
    input logic [7:0] err_code_out,
    input logic [7:0] cur_addr_out,
    input logic [7:0] ibus_addr_out,
    input logic ibus_valid_out,
    input logic [7:0] ibus_data_out,
    input logic ibus_data_oe_out
);
    logic open_q;
    logic take_w;
    logic rd_map_w;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    // A start is ignored while a set command is still open
    assign take_w = cmd_start_in && ready_out && !open_q;
    assign rd_map_w = cur_addr_out inside {8'hCF, 8'hF0, 8'hF7, 8'hFA};

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
            open_q <= 1'b0;
        else if (take_w && !cmd_kind_in[0])
            open_q <= 1'b1;
        else if (cmd_end_in && ready_out)
            open_q <= 1'b0;
    end

    a_addr_quiet: assert property (
        $changed(ibus_addr_out) |-> !ibus_valid_out && !$past(ibus_valid_out))
        else $error("bus address moved while strobe high");
    a_data_strobed: assert property (
        $changed(ibus_data_out) |-> ibus_valid_out && $past(ibus_valid_out))
        else $error("bus data moved while strobe low");
    a_strobe_width: assert property (
        $rose(ibus_valid_out) |-> ibus_valid_out[*7] ##1 !ibus_valid_out)
        else $error("strobe width wrong");
    a_oe_write_only: assert property (
        ibus_data_oe_out |-> ibus_valid_out && !ibus_addr_out[7])
        else $error("data driven outside a write strobe");
    a_busy_strobe: assert property (
        ibus_valid_out |-> !ready_out)
        else $error("ready high during a bus transfer");
    a_ready_back: assert property (
        $fell(ibus_valid_out) |-> ready_out)
        else $error("ready not back after strobe");
    a_addr_report: assert property (
        take_w && cmd_kind_in == 2'h1 |=>
            resp_valid_out && resp_byte_out == cur_addr_out)
        else $error("address query answer wrong");
    a_dir_refuse: assert property (
        take_w && cmd_kind_in == 2'h3 && !cur_addr_out[7] |=>
            err_valid_out && err_code_out == 8'h42)
        else $error("query of write location not refused");
    a_bad_read_loc: assert property (
        take_w && cmd_kind_in == 2'h3 && cur_addr_out[7] && !rd_map_w |=>
            err_valid_out && err_code_out == 8'h41)
        else $error("query of unmapped location not refused");
    a_read_answer: assert property (
        take_w && cmd_kind_in == 2'h3 && rd_map_w |-> ##[7:12] resp_valid_out)
        else $error("data query not answered");
endmodule // ibsa_top_chk

bind ibsa_top ibsa_top_chk chk_i (.*);
